// ---- iemb_pkg.sv ----
/*
 * Constants for the interrupt enable mask bank: register offsets, field
 * positions, implemented-bit masks and reset values.
 * Assumes a 16-bit register port with byte addresses on an 8-bit address.
 */
`default_nettype none

package iemb_pkg;

   localparam int REG_ADDR_W = 8;
   localparam int REG_DATA_W = 16;

   // register offsets
   localparam logic [7:0] OFS_ENABLE_WORD_0 = 8'h00;
   localparam logic [7:0] OFS_ENABLE_WORD_1 = 8'h04;
   localparam logic [7:0] OFS_FLAG_WORD_0 = 8'h08;
   localparam logic [7:0] OFS_FLAG_WORD_1 = 8'h0C;
   localparam logic [7:0] OFS_REQUEST_WORD_0 = 8'h10;
   localparam logic [7:0] OFS_REQUEST_WORD_1 = 8'h14;

   // first enable word fields
   localparam int POS_SERIAL_PERIPH_EVENT = 8;
   localparam int POS_TIMER_THREE = 7;
   localparam int POS_TIMER_TWO = 6;
   localparam int POS_OUT_COMPARE_TWO = 5;
   localparam int POS_TIMER_ONE = 3;
   localparam int POS_OUT_COMPARE_ONE = 2;
   localparam int POS_IN_CAPTURE_ONE = 1;
   localparam int POS_EXT_PIN_ZERO = 0;

   // second enable word fields
   localparam int POS_COMPARATOR_THREE = 15;
   localparam int POS_COMPARATOR_TWO = 14;
   localparam int POS_COMPARATOR_ONE = 13;
   localparam int POS_CHANGE_NOTIFY = 11;
   localparam int POS_PULSE_GEN_FOUR = 6;
   localparam int POS_PULSE_GEN_THREE = 5;
   localparam int POS_PULSE_GEN_TWO = 4;
   localparam int POS_PULSE_GEN_ONE = 3;
   localparam int POS_SPECIAL_EVENT_MATCH = 2;
   localparam int POS_EXT_PIN_TWO = 1;
   localparam int POS_EXT_PIN_ONE = 0;

   // implemented bits: word 0 bits 8..5 and 3..0, word 1 bits 15..13, 11, 6..0
   localparam logic [15:0] IMPL_MASK_WORD_0 = 16'h01EF;
   localparam logic [15:0] IMPL_MASK_WORD_1 = 16'hE87F;

   localparam logic [15:0] RESET_ENABLE_WORD = 16'h0000;
   localparam logic [15:0] RESET_FLAG_WORD = 16'h0000;
   localparam logic [15:0] RESET_READ_WORD = 16'h0000;

endpackage

`default_nettype wire

// ---- iemb_mask_bank.sv ----
/*
 * Interrupt enable mask bank: two enable words, two sticky pending-flag
 * words, per-source gated requests and one level interrupt output.
 * Assumes one clock, a register master that issues one-cycle strobes
 * never together, and source event inputs synchronous to clk_sys.
 */
// Design decisions made here: the address map and the plain strobed port.
`default_nettype none

module iemb_mask_bank
   import iemb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [REG_ADDR_W-1:0] regAddr,
   input wire logic [REG_DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [REG_DATA_W-1:0] regRdData,
   input wire logic [15:0] srcEvent0,
   input wire logic [15:0] srcEvent1,
   output logic [15:0] srcRequest0,
   output logic [15:0] srcRequest1,
   output logic irqOut
);

   typedef struct packed {
      logic [15:0] enableWord0;
      logic [15:0] enableWord1;
      logic [15:0] flagWord0;
      logic [15:0] flagWord1;
      logic [15:0] rdData;
   } iemb_state_s;

   iemb_state_s state;
   iemb_state_s next_state;

   wire logic [15:0] req0;
   wire logic [15:0] req1;

   // enable fields by source
   logic serialPeriphEventEn;
   logic timerThreeEn;
   logic timerTwoEn;
   logic outCompareTwoEn;
   logic timerOneEn;
   logic outCompareOneEn;
   logic inCaptureOneEn;
   logic extPinZeroEn;
   logic comparatorThreeEn;
   logic comparatorTwoEn;
   logic comparatorOneEn;
   logic changeNotifyEn;
   logic pulseGenFourEn;
   logic pulseGenThreeEn;
   logic pulseGenTwoEn;
   logic pulseGenOneEn;
   logic specialEventMatchEn;
   logic extPinTwoEn;
   logic extPinOneEn;

   assign serialPeriphEventEn = state.enableWord0[POS_SERIAL_PERIPH_EVENT];
   assign timerThreeEn = state.enableWord0[POS_TIMER_THREE];
   assign timerTwoEn = state.enableWord0[POS_TIMER_TWO];
   assign outCompareTwoEn = state.enableWord0[POS_OUT_COMPARE_TWO];
   assign timerOneEn = state.enableWord0[POS_TIMER_ONE];
   assign outCompareOneEn = state.enableWord0[POS_OUT_COMPARE_ONE];
   assign inCaptureOneEn = state.enableWord0[POS_IN_CAPTURE_ONE];
   assign extPinZeroEn = state.enableWord0[POS_EXT_PIN_ZERO];
   assign comparatorThreeEn = state.enableWord1[POS_COMPARATOR_THREE];
   assign comparatorTwoEn = state.enableWord1[POS_COMPARATOR_TWO];
   assign comparatorOneEn = state.enableWord1[POS_COMPARATOR_ONE];
   assign changeNotifyEn = state.enableWord1[POS_CHANGE_NOTIFY];
   assign pulseGenFourEn = state.enableWord1[POS_PULSE_GEN_FOUR];
   assign pulseGenThreeEn = state.enableWord1[POS_PULSE_GEN_THREE];
   assign pulseGenTwoEn = state.enableWord1[POS_PULSE_GEN_TWO];
   assign pulseGenOneEn = state.enableWord1[POS_PULSE_GEN_ONE];
   assign specialEventMatchEn = state.enableWord1[POS_SPECIAL_EVENT_MATCH];
   assign extPinTwoEn = state.enableWord1[POS_EXT_PIN_TWO];
   assign extPinOneEn = state.enableWord1[POS_EXT_PIN_ONE];

   // one gate per implemented source; each drives only its own request bit
   iemb_gate_cell gateSerialPeriphEvent (
      .pendingFlag(state.flagWord0[POS_SERIAL_PERIPH_EVENT]),
      .enable(serialPeriphEventEn),
      .request(req0[POS_SERIAL_PERIPH_EVENT])
   );
   iemb_gate_cell gateTimerThree (
      .pendingFlag(state.flagWord0[POS_TIMER_THREE]),
      .enable(timerThreeEn),
      .request(req0[POS_TIMER_THREE])
   );
   iemb_gate_cell gateTimerTwo (
      .pendingFlag(state.flagWord0[POS_TIMER_TWO]),
      .enable(timerTwoEn),
      .request(req0[POS_TIMER_TWO])
   );
   iemb_gate_cell gateOutCompareTwo (
      .pendingFlag(state.flagWord0[POS_OUT_COMPARE_TWO]),
      .enable(outCompareTwoEn),
      .request(req0[POS_OUT_COMPARE_TWO])
   );
   iemb_gate_cell gateTimerOne (
      .pendingFlag(state.flagWord0[POS_TIMER_ONE]),
      .enable(timerOneEn),
      .request(req0[POS_TIMER_ONE])
   );
   iemb_gate_cell gateOutCompareOne (
      .pendingFlag(state.flagWord0[POS_OUT_COMPARE_ONE]),
      .enable(outCompareOneEn),
      .request(req0[POS_OUT_COMPARE_ONE])
   );
   iemb_gate_cell gateInCaptureOne (
      .pendingFlag(state.flagWord0[POS_IN_CAPTURE_ONE]),
      .enable(inCaptureOneEn),
      .request(req0[POS_IN_CAPTURE_ONE])
   );
   iemb_gate_cell gateExtPinZero (
      .pendingFlag(state.flagWord0[POS_EXT_PIN_ZERO]),
      .enable(extPinZeroEn),
      .request(req0[POS_EXT_PIN_ZERO])
   );
   iemb_gate_cell gateComparatorThree (
      .pendingFlag(state.flagWord1[POS_COMPARATOR_THREE]),
      .enable(comparatorThreeEn),
      .request(req1[POS_COMPARATOR_THREE])
   );
   iemb_gate_cell gateComparatorTwo (
      .pendingFlag(state.flagWord1[POS_COMPARATOR_TWO]),
      .enable(comparatorTwoEn),
      .request(req1[POS_COMPARATOR_TWO])
   );
   iemb_gate_cell gateComparatorOne (
      .pendingFlag(state.flagWord1[POS_COMPARATOR_ONE]),
      .enable(comparatorOneEn),
      .request(req1[POS_COMPARATOR_ONE])
   );
   iemb_gate_cell gateChangeNotify (
      .pendingFlag(state.flagWord1[POS_CHANGE_NOTIFY]),
      .enable(changeNotifyEn),
      .request(req1[POS_CHANGE_NOTIFY])
   );
   iemb_gate_cell gatePulseGenFour (
      .pendingFlag(state.flagWord1[POS_PULSE_GEN_FOUR]),
      .enable(pulseGenFourEn),
      .request(req1[POS_PULSE_GEN_FOUR])
   );
   iemb_gate_cell gatePulseGenThree (
      .pendingFlag(state.flagWord1[POS_PULSE_GEN_THREE]),
      .enable(pulseGenThreeEn),
      .request(req1[POS_PULSE_GEN_THREE])
   );
   iemb_gate_cell gatePulseGenTwo (
      .pendingFlag(state.flagWord1[POS_PULSE_GEN_TWO]),
      .enable(pulseGenTwoEn),
      .request(req1[POS_PULSE_GEN_TWO])
   );
   iemb_gate_cell gatePulseGenOne (
      .pendingFlag(state.flagWord1[POS_PULSE_GEN_ONE]),
      .enable(pulseGenOneEn),
      .request(req1[POS_PULSE_GEN_ONE])
   );
   iemb_gate_cell gateSpecialEventMatch (
      .pendingFlag(state.flagWord1[POS_SPECIAL_EVENT_MATCH]),
      .enable(specialEventMatchEn),
      .request(req1[POS_SPECIAL_EVENT_MATCH])
   );
   iemb_gate_cell gateExtPinTwo (
      .pendingFlag(state.flagWord1[POS_EXT_PIN_TWO]),
      .enable(extPinTwoEn),
      .request(req1[POS_EXT_PIN_TWO])
   );
   iemb_gate_cell gateExtPinOne (
      .pendingFlag(state.flagWord1[POS_EXT_PIN_ONE]),
      .enable(extPinOneEn),
      .request(req1[POS_EXT_PIN_ONE])
   );

   // absent sources never request
   for (genvar i = 0; i < 16; i++) begin : g_absent
      if (!IMPL_MASK_WORD_0[i]) begin : g_w0
         assign req0[i] = 1'b0;
      end
      if (!IMPL_MASK_WORD_1[i]) begin : g_w1
         assign req1[i] = 1'b0;
      end
   end

   logic wrEnable0;
   logic wrEnable1;
   logic wrFlag0;
   logic wrFlag1;

   assign wrEnable0 = regWr && (regAddr == OFS_ENABLE_WORD_0);
   assign wrEnable1 = regWr && (regAddr == OFS_ENABLE_WORD_1);
   assign wrFlag0 = regWr && (regAddr == OFS_FLAG_WORD_0);
   assign wrFlag1 = regWr && (regAddr == OFS_FLAG_WORD_1);

   always_comb begin
      logic [15:0] clr0;
      logic [15:0] clr1;
      clr0 = 16'h0000;
      clr1 = 16'h0000;
      next_state = state;

      // unimplemented bits never store a one
      if (wrEnable0) begin
         next_state.enableWord0 = regWrData & IMPL_MASK_WORD_0;
      end
      if (wrEnable1) begin
         next_state.enableWord1 = regWrData & IMPL_MASK_WORD_1;
      end

      // write one to clear; an event in the same cycle wins over the clear
      if (wrFlag0) begin
         clr0 = regWrData;
      end
      if (wrFlag1) begin
         clr1 = regWrData;
      end
      // flags follow events whatever the enables hold
      for (int i = 0; i < 16; i++) begin
         if (!IMPL_MASK_WORD_0[i]) begin
            next_state.flagWord0[i] = 1'b0;
         end else if (srcEvent0[i]) begin
            next_state.flagWord0[i] = 1'b1;
         end else if (clr0[i]) begin
            next_state.flagWord0[i] = 1'b0;
         end
         if (!IMPL_MASK_WORD_1[i]) begin
            next_state.flagWord1[i] = 1'b0;
         end else if (srcEvent1[i]) begin
            next_state.flagWord1[i] = 1'b1;
         end else if (clr1[i]) begin
            next_state.flagWord1[i] = 1'b0;
         end
      end

      // read data stands only in the cycle after the strobe
      next_state.rdData = 16'h0000;
      if (regRd) begin
         case (regAddr)
            OFS_ENABLE_WORD_0: begin
               next_state.rdData = state.enableWord0;
            end
            OFS_ENABLE_WORD_1: begin
               next_state.rdData = state.enableWord1;
            end
            OFS_FLAG_WORD_0: begin
               next_state.rdData = state.flagWord0;
            end
            OFS_FLAG_WORD_1: begin
               next_state.rdData = state.flagWord1;
            end
            OFS_REQUEST_WORD_0: begin
               next_state.rdData = req0;
            end
            OFS_REQUEST_WORD_1: begin
               next_state.rdData = req1;
            end
            default: begin
               next_state.rdData = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state.enableWord0 <= RESET_ENABLE_WORD;
         state.enableWord1 <= RESET_ENABLE_WORD;
         state.flagWord0 <= RESET_FLAG_WORD;
         state.flagWord1 <= RESET_FLAG_WORD;
         state.rdData <= RESET_READ_WORD;
      end else begin
         state <= next_state;
      end
   end

   assign regRdData = state.rdData;
   assign srcRequest0 = req0;
   assign srcRequest1 = req1;
   // level output, drops as soon as the last unmasked flag clears
   assign irqOut = (|req0) | (|req1);

endmodule

// one source gate: the flag is only read here, so masking never loses an event
module iemb_gate_cell #(
   parameter int WIDTH = 1
) (
   input wire logic [WIDTH-1:0] pendingFlag,
   input wire logic [WIDTH-1:0] enable,
   output logic [WIDTH-1:0] request
);
   assign request = pendingFlag & enable;
endmodule

`default_nettype wire

// ---- iemb_cpu_model.sv ----
/* cpu side stand-in: latches the level interrupt as the vector logic would
   assumes the mask bank drives irqOut from registers on clk_sys */
`default_nettype none
module iemb_cpu_model (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic irqOut,
   output logic irqTaken
);
   timeunit 1ns;
   timeprecision 1ns;
   // one cycle late on purpose: the cpu samples, it never sees combinational glitches
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) irqTaken <= 1'b0;
      else irqTaken <= irqOut;
   end
endmodule
`default_nettype wire

// ---- iemb_mask_bank_asserts.sv ----
/* port relations of the mask bank
   assumes a bind from the bench top, one clock domain */
`default_nettype none
module iemb_mask_bank_asserts
   import iemb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [REG_ADDR_W-1:0] regAddr,
   input wire logic [REG_DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [REG_DATA_W-1:0] regRdData,
   input wire logic [15:0] srcRequest0,
   input wire logic [15:0] srcRequest1,
   input wire logic irqOut
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_rd_idle; !$past(regRd) |-> regRdData == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_req_impl; ((srcRequest0 & ~IMPL_MASK_WORD_0) | (srcRequest1 & ~IMPL_MASK_WORD_1)) == 16'h0000; endproperty
   a_req_impl: assert property (p_req_impl) else $error("request on absent bit");
   property p_irq; irqOut == (|{srcRequest1, srcRequest0}); endproperty
   a_irq: assert property (p_irq) else $error("irq not or of requests");
   property p_en0_off; regWr && regAddr == OFS_ENABLE_WORD_0 && regWrData == 16'h0000 |=> srcRequest0 == 16'h0000; endproperty
   a_en0_off: assert property (p_en0_off) else $error("word 0 request while masked");
   property p_en1_off; regWr && regAddr == OFS_ENABLE_WORD_1 && regWrData == 16'h0000 |=> srcRequest1 == 16'h0000; endproperty
   a_en1_off: assert property (p_en1_off) else $error("word 1 request while masked");
   property p_req_rd; regRd && regAddr == OFS_REQUEST_WORD_0 |=> regRdData == $past(srcRequest0); endproperty
   a_req_rd: assert property (p_req_rd) else $error("request word read mismatch");
   property p_flag_rd; regRd && regAddr == OFS_FLAG_WORD_1 |=> (regRdData & ~IMPL_MASK_WORD_1) == 16'h0000; endproperty
   a_flag_rd: assert property (p_flag_rd) else $error("flag on absent bit");
   property p_unmapped; regRd && regAddr == 8'h20 |=> regRdData == 16'h0000; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_irq: cover property (irqOut);
   c_flag: cover property (regRd && regAddr == OFS_FLAG_WORD_0);
   c_req1: cover property (srcRequest1 != 16'h0000);
endmodule
`default_nettype wire

// ---- interrupt_enable_mask_bank_tb.sv ----
/* self-checking bench for the mask bank
   assumes iemb_pkg, the bank, the cpu model and the checker are compiled first */
`default_nettype none
module interrupt_enable_mask_bank_tb
   import iemb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, irqOut, irqTaken;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000, srcEvent0 = 16'h0000, srcEvent1 = 16'h0000;
   logic [15:0] regRdData, srcRequest0, srcRequest1;
   int fail_count = 0, n_compared = 0;
   always #50 clk_sys = ~clk_sys;
   iemb_mask_bank uut (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .srcEvent0(srcEvent0), .srcEvent1(srcEvent1),
      .srcRequest0(srcRequest0), .srcRequest1(srcRequest1), .irqOut(irqOut));
   iemb_cpu_model cpu (.clk_sys(clk_sys), .rst_b(rst_b), .irqOut(irqOut), .irqTaken(irqTaken));
   task final_report;
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1;
      chk({16'h0000, regRdData}, {16'h0000, e});
   endtask
   task ev(input logic [15:0] a, input logic [15:0] b);
      @(posedge clk_sys);
      srcEvent0 <= a;
      srcEvent1 <= b;
      @(posedge clk_sys);
      srcEvent0 <= 16'h0000;
      srcEvent1 <= 16'h0000;
      #1;
   endtask
   task t_reset_impl;
      rd(OFS_ENABLE_WORD_0, 16'h0000);
      rd(OFS_FLAG_WORD_1, 16'h0000);
      wr(OFS_ENABLE_WORD_0, 16'hFFFF);
      wr(OFS_ENABLE_WORD_1, 16'hFFFF);
      rd(OFS_ENABLE_WORD_0, 16'h01EF);
      rd(OFS_ENABLE_WORD_1, 16'hE87F);
      rd(8'h20, 16'h0000);
   endtask
   task t_map;
      logic [31:0] b;
      logic [31:0] m;
      m = {IMPL_MASK_WORD_1, IMPL_MASK_WORD_0};
      for (int i = 0; i < 32; i++) begin
         b = 32'h0000_0001 << i;
         wr(OFS_ENABLE_WORD_0, b[15:0]);
         wr(OFS_ENABLE_WORD_1, b[31:16]);
         ev(16'hFFFF, 16'hFFFF);
         chk({srcRequest1, srcRequest0}, b & m);
         chk({31'h0000_0000, irqOut}, {31'h0000_0000, |(b & m)});
         wr(OFS_FLAG_WORD_0, 16'hFFFF);
         wr(OFS_FLAG_WORD_1, 16'hFFFF);
      end
   endtask
   task t_keep_flag;
      wr(OFS_ENABLE_WORD_0, 16'h0000);
      ev(16'h0004, 16'h0000);
      chk({16'h0000, srcRequest0}, 32'h0000_0000);
      rd(OFS_FLAG_WORD_0, 16'h0004);
      wr(OFS_ENABLE_WORD_0, 16'h0004);
      rd(OFS_REQUEST_WORD_0, 16'h0004);
      chk({31'h0000_0000, irqTaken}, 32'h0000_0001);
      wr(OFS_FLAG_WORD_0, 16'h0004);
      chk({15'h0000, irqOut, srcRequest0}, 32'h0000_0000);
      @(posedge clk_sys);
      #1;
      chk({31'h0000_0000, irqTaken}, 32'h0000_0000);
   endtask
   task t_word1;
      wr(OFS_ENABLE_WORD_1, 16'h0800);
      ev(16'h0000, 16'h1800);
      rd(OFS_FLAG_WORD_1, 16'h0800);
      rd(OFS_REQUEST_WORD_1, 16'h0800);
      wr(OFS_REQUEST_WORD_1, 16'h0000);
      rd(OFS_REQUEST_WORD_1, 16'h0800);
      // event and clear in one cycle: the set must win
      @(posedge clk_sys);
      srcEvent1 <= 16'h0800;
      regWr <= 1'b1;
      regAddr <= OFS_FLAG_WORD_1;
      regWrData <= 16'h0800;
      @(posedge clk_sys);
      srcEvent1 <= 16'h0000;
      regWr <= 1'b0;
      #1;
      rd(OFS_FLAG_WORD_1, 16'h0800);
      wr(OFS_FLAG_WORD_1, 16'h0800);
      chk({15'h0000, irqOut, srcRequest1}, 32'h0000_0000);
   endtask
   task t_reset_mid;
      wr(OFS_ENABLE_WORD_0, 16'hFFFF);
      wr(OFS_ENABLE_WORD_1, 16'hFFFF);
      ev(16'hFFFF, 16'hFFFF);
      chk({31'h0000_0000, irqOut}, 32'h0000_0001);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      #1;
      chk({15'h0000, irqOut, srcRequest1}, 32'h0000_0000);
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(OFS_ENABLE_WORD_0, 16'h0000);
      rd(OFS_ENABLE_WORD_1, 16'h0000);
      rd(OFS_FLAG_WORD_0, 16'h0000);
      chk({31'h0000_0000, irqTaken}, 32'h0000_0000);
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset_impl();
      t_map();
      t_word1();
      t_keep_flag();
      t_reset_mid();
      final_report();
   end
   initial begin
      #2000000;
      fail_count++;
      final_report();
   end
endmodule
bind iemb_mask_bank iemb_mask_bank_asserts chk (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .srcRequest0(srcRequest0),
   .srcRequest1(srcRequest1), .irqOut(irqOut));
`default_nettype wire
